// ### logic/gio_port.sv
// Purpose: 48-line two-way port with filtered inputs and per-bit edge interrupts
// Assumes: pins synchronous to core_clk_i; APB3 master outside
// Notes: data words read the filtered line for input groups, the latch for output groups
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
`include "gio_defs.svh"
module gio_port
    import gio_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`GIO_LINES-1:0] line_i,
    output gio_pins_t pins_o,
    output logic irq_o
);

    // lower word holds bits 31:0, upper word bits 47:32 in its low half
    function automatic logic [31:0] rd_word(input logic [47:0] v, input logic hi);
        logic [31:0] w;
        if (hi) begin
            w = {16'h0000, v[47:32]};
        end else begin
            w = v[31:0];
        end
        rd_word = w;
    endfunction

    // the other word of the 48-bit value is kept untouched
    function automatic logic [47:0] wr_word(input logic [47:0] v, input logic [31:0] d,
                                            input logic hi);
        logic [47:0] w;
        if (hi) begin
            w = {d[15:0], v[31:0]};
        end else begin
            w = {v[47:32], d};
        end
        wr_word = w;
    endfunction

    function automatic logic [47:0] grp_mask(input logic [5:0] g);
        logic [47:0] m;
        m = 48'h0000_0000_0000;
        for (int i = 0; i < `GIO_GROUPS; i++) begin
            m[i*8 +: 8] = {8{g[i]}};
        end
        grp_mask = m;
    endfunction

    localparam gio_fcnt_t FILT_LAST = gio_fcnt_t'(`GIO_FILT_CYC - 1);

    // port latch, direction and pin enables
    logic [47:0] out_r;
    logic [47:0] out_nxt;
    logic [5:0] dir_r;
    logic [5:0] dir_nxt;
    logic [47:0] oe_n_r;
    logic [47:0] oe_n_nxt;

    // interrupt configuration and pending flags
    logic [47:0] ien_r;
    logic [47:0] ien_nxt;
    logic [47:0] edge_r;
    logic [47:0] edge_nxt;
    logic [47:0] pend_r;
    logic [47:0] pend_nxt;
    logic irq_r;
    logic irq_nxt;

    // input filter
    logic [47:0] filt_r;
    logic [47:0] filt_nxt;
    gio_fcnt_t cnt_r [`GIO_LINES];
    gio_fcnt_t cnt_nxt [`GIO_LINES];

    // bus answer
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    logic [`GIO_ADDR_W-1:0] ofs;
    logic wr_en;
    logic rd_en;
    logic [47:0] in_mask;
    logic [47:0] rd_view;
    logic [47:0] rise;
    logic [47:0] fall;
    logic [47:0] evt;
    logic [47:0] clr;

    // only the low five address bits decode, so any 32-byte base aliases here
    assign ofs = paddr_i[`GIO_ADDR_W-1:0];
    assign wr_en = psel_i & penable_i & pready_r & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pready_r & ~pwrite_i;

    // filter: a new level is accepted only after it has stood for FILT_CYC samples
    always_comb begin
        for (int i = 0; i < `GIO_LINES; i++) begin
            filt_nxt[i] = filt_r[i];
            cnt_nxt[i] = '0;
            if (line_i[i] != filt_r[i]) begin
                if (cnt_r[i] == FILT_LAST) begin
                    filt_nxt[i] = line_i[i];
                end else begin
                    cnt_nxt[i] = cnt_r[i] + gio_fcnt_t'(1);
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            filt_r <= `GIO_RST_48;
            for (int i = 0; i < `GIO_LINES; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            filt_r <= filt_nxt;
            for (int i = 0; i < `GIO_LINES; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    // edges are taken from filtered levels of input groups only, so a driven
    // output group never raises an event from its own latch
    always_comb begin
        in_mask = ~grp_mask(dir_r);
        rise = filt_nxt & ~filt_r;
        fall = ~filt_nxt & filt_r;
        // edge bit 1 selects rising, 0 falling
        evt = in_mask & ((edge_r & rise) | (~edge_r & fall));
    end

    // status words clear where a one is written; zeros leave pending alone
    always_comb begin
        clr = 48'h0000_0000_0000;
        if (wr_en) begin
            if (ofs == `GIO_OFS_STAT_LO) begin
                clr = wr_word(`GIO_RST_48, pwdata_i, 1'b0);
            end
            if (ofs == `GIO_OFS_STAT_HI) begin
                clr = wr_word(`GIO_RST_48, pwdata_i, 1'b1);
            end
        end
    end

    // a data read shows the line for input groups and the latch for output groups
    assign rd_view = (filt_r & in_mask) | (out_r & ~in_mask);

    // the upper data word always carries the direction field as well, so software
    // must write the wanted direction with every upper data write
    always_comb begin
        out_nxt = out_r;
        dir_nxt = dir_r;
        if (wr_en && ofs == `GIO_OFS_DATA_LO) begin
            out_nxt = wr_word(out_r, pwdata_i, 1'b0);
        end
        if (wr_en && ofs == `GIO_OFS_DATA_HI) begin
            out_nxt = wr_word(out_r, pwdata_i, 1'b1);
            dir_nxt = pwdata_i[`GIO_DIR_LSB +: `GIO_GROUPS];
        end
        // one byte lane per group; direction bit 1 drives the group
        // enables follow the next direction so the pins turn at the write edge
        oe_n_nxt = ~grp_mask(dir_nxt);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            out_r <= `GIO_RST_48;
            dir_r <= `GIO_RST_DIR;
            oe_n_r <= {48{1'b1}};
        end else begin
            out_r <= out_nxt;
            dir_r <= dir_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    always_comb begin
        ien_nxt = ien_r;
        if (wr_en && ofs == `GIO_OFS_IEN_LO) begin
            ien_nxt = wr_word(ien_r, pwdata_i, 1'b0);
        end
        if (wr_en && ofs == `GIO_OFS_IEN_HI) begin
            ien_nxt = wr_word(ien_r, pwdata_i, 1'b1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ien_r <= `GIO_RST_48;
        end else begin
            ien_r <= ien_nxt;
        end
    end

    always_comb begin
        edge_nxt = edge_r;
        if (wr_en && ofs == `GIO_OFS_EDGE_LO) begin
            edge_nxt = wr_word(edge_r, pwdata_i, 1'b0);
        end
        if (wr_en && ofs == `GIO_OFS_EDGE_HI) begin
            edge_nxt = wr_word(edge_r, pwdata_i, 1'b1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            edge_r <= `GIO_RST_48;
        end else begin
            edge_r <= edge_nxt;
        end
    end

    // set beats clear so an edge in the clearing cycle is kept
    always_comb begin
        pend_nxt = (pend_r & ~clr) | evt;
        irq_nxt = |(pend_nxt & ien_nxt);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pend_r <= `GIO_RST_48;
            irq_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_comb begin
        prdata_nxt = prdata_r;
        // one fixed wait state: data are fetched in the first access cycle
        pready_nxt = psel_i & penable_i & ~pready_r;
        // no offset of the window is refused, unaligned ones read zero, so no error answer exists
        pslverr_nxt = 1'b0;
        if (rd_en) begin
            unique case (ofs)
                `GIO_OFS_DATA_LO: begin
                    prdata_nxt = rd_word(rd_view, 1'b0);
                end

                `GIO_OFS_DATA_HI: begin
                    prdata_nxt = rd_word(rd_view, 1'b1) | {10'h000, dir_r, 16'h0000};
                end

                `GIO_OFS_IEN_LO: begin
                    prdata_nxt = rd_word(ien_r, 1'b0);
                end

                `GIO_OFS_IEN_HI: begin
                    prdata_nxt = rd_word(ien_r, 1'b1);
                end

                `GIO_OFS_EDGE_LO: begin
                    prdata_nxt = rd_word(edge_r, 1'b0);
                end

                `GIO_OFS_EDGE_HI: begin
                    prdata_nxt = rd_word(edge_r, 1'b1);
                end

                `GIO_OFS_STAT_LO: begin
                    prdata_nxt = rd_word(pend_r, 1'b0);
                end

                `GIO_OFS_STAT_HI: begin
                    prdata_nxt = rd_word(pend_r, 1'b1);
                end

                // unaligned offsets read as zero
                default: begin
                    prdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign pins_o.level = out_r;
    assign pins_o.oe_n = oe_n_r;
    assign irq_o = irq_r;

endmodule
`default_nettype wire

// ### logic/gio_defs.svh
// Purpose: constants of the 48-line digital port with edge interrupts
// Assumes: 40 MHz core clock, APB register access within a 32-byte window
// Notes: all offsets are byte addresses inside the window
// Function
// - Forty-eight two-way lines act as a plain port: outputs hold the written value, inputs read the line.
// - The lines form six byte-wide groups of eight.
// - Software sets each group's direction by a register write alone.
// - Every input bit may raise an interrupt, gated by its own enable bit.
// - Each input bit has its own choice of rising or falling trigger edge.
// - All enabled pending bits are merged into one interrupt output.
// - A bit's interrupt is raised only on a transition that matches its selected edge.
// - Input levels pass a digital filter before they are read or edge-checked.
// - Registers are decoded within a 32-byte window on any 32-byte aligned base.
// - A data bit of one means a high line level and zero a low level.
`ifndef GIO_DEFS_SVH
`define GIO_DEFS_SVH
`define GIO_LINES 48
`define GIO_GROUPS 6
`define GIO_ADDR_W 5
`define GIO_OFS_DATA_LO 5'h00
`define GIO_OFS_DATA_HI 5'h04
`define GIO_OFS_IEN_LO 5'h08
`define GIO_OFS_IEN_HI 5'h0C
`define GIO_OFS_EDGE_LO 5'h10
`define GIO_OFS_EDGE_HI 5'h14
`define GIO_OFS_STAT_LO 5'h18
`define GIO_OFS_STAT_HI 5'h1C
`define GIO_DIR_LSB 16
`define GIO_RST_DIR 6'h00
`define GIO_RST_48 48'h0000_0000_0000
`define GIO_CLK_MHZ 40
`define GIO_FILT_NS 100
`define GIO_FILT_CYC ((`GIO_FILT_NS * `GIO_CLK_MHZ + 999) / 1000)
`define GIO_FILT_W 3
`endif

// ### logic/gio_pkg.sv
// Purpose: types of the digital port
// Assumes: gio_defs.svh included first
// Notes: pin group travels as one packed struct
`default_nettype none
`include "gio_defs.svh"
package gio_pkg;
    typedef struct packed {
        logic [`GIO_LINES-1:0] level;
        logic [`GIO_LINES-1:0] oe_n;
    } gio_pins_t;
    typedef logic [`GIO_FILT_W-1:0] gio_fcnt_t;
endpackage
`default_nettype wire

// ### dv/gio_ext_dev.sv
// Purpose: external devices on the port lines
// Assumes: devices always drive the input groups
// Notes: no pulls on the lines, so an undriven line is never left to the simulator
`default_nettype none
`include "gio_defs.svh"
module gio_ext_dev
    import gio_pkg::*;
(
    input wire logic [`GIO_LINES-1:0] drive_i,
    input wire gio_pins_t pins_i,
    output logic [`GIO_LINES-1:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the port wins where its enable is low, the device elsewhere
    assign line_o = (pins_i.oe_n & drive_i) | (~pins_i.oe_n & pins_i.level);
endmodule
`default_nettype wire

// ### dv/gio_port_checker.sv
// Purpose: assertions on the bus answer and the port pins of the digital port
// Assumes: one clock domain, pready one wait state after setup
// Notes: a write takes effect at the edge where pready is sampled
`default_nettype none
`include "gio_defs.svh"
module gio_checker
    import gio_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [`GIO_LINES-1:0] line_i,
    input wire gio_pins_t pins_o,
    input wire logic irq_o
);
    logic wr_done;
    logic [5:0] grp;
    assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
    assign grp = {pins_o.oe_n[40], pins_o.oe_n[32], pins_o.oe_n[24], pins_o.oe_n[16],
        pins_o.oe_n[8], pins_o.oe_n[0]};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    AST_ONE_WAIT: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("ready late");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready stuck");
    AST_NO_ERR: assert property (pready_o |-> !pslverr_o)
        else $error("error answer given");
    AST_RESET_INPUTS: assert property ($past(srst_i) |-> &pins_o.oe_n && !irq_o)
        else $error("reset state wrong");
    AST_GROUP_DIR: assert property (pins_o.oe_n == {{8{grp[5]}}, {8{grp[4]}},
        {8{grp[3]}}, {8{grp[2]}}, {8{grp[1]}}, {8{grp[0]}}}) else $error("group split");
    AST_DIR_WRITE: assert property (wr_done && paddr_i[4:0] == `GIO_OFS_DATA_HI
        |=> grp == ~$past(pwdata_i[21:16])) else $error("direction not taken");
    AST_LATCH_LO: assert property (wr_done && paddr_i[4:0] == `GIO_OFS_DATA_LO
        |=> pins_o.level[31:0] == $past(pwdata_i)) else $error("latch not taken");
    AST_HI_ZERO: assert property (pready_o && !pwrite_i
        && paddr_i[4:0] == `GIO_OFS_DATA_HI |-> prdata_o[31:22] == 10'h000)
        else $error("spare bits set");
    AST_IRQ_HOLD: assert property (irq_o && !wr_done |=> irq_o)
        else $error("irq dropped alone");
    CV_IRQ: cover property ($rose(irq_o));
    CV_DIR: cover property (wr_done && paddr_i[4:0] == `GIO_OFS_DATA_HI);
    CV_READ: cover property (pready_o && !pwrite_i);
endmodule
bind gio_port gio_checker i_gio_checker (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .line_i, .pins_o, .irq_o);
`default_nettype wire

// ### dv/tb_gio_port.sv
// Purpose: self-checking bench for the 48-line port
// Assumes: filter settles within 6 cycles
// Notes: expected words come from the bench's own latch and drive copies
`default_nettype none
`include "gio_defs.svh"
module tb_gio_port
    import gio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    logic [47:0] line_i;
    logic [47:0] drv = 48'h0;
    gio_pins_t pins_o;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 57966;
    gio_port i_gio_port (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .line_i, .pins_o, .irq_o);
    gio_ext_dev i_gio_ext_dev (.drive_i(drv), .pins_i(pins_o), .line_o(line_i));
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one idle cycle after each transfer keeps every strobe single-driven per step
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= 32'h0000_0020 | {27'h0, a};
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    initial begin
        logic [47:0] v;
        logic [47:0] e;
        logic [31:0] q;
        logic [5:0] d;
        logic [15:0] d16;
        repeat (4) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        apb(1'b0, `GIO_OFS_DATA_HI, 32'h0, q);
        chk(q, 48'h0, "hi after reset");
        apb(1'b0, `GIO_OFS_STAT_LO, 32'h0, q);
        chk(q, 48'h0, "pending after reset");
        $display("reset test done");
        for (int t = 0; t < 2; t++) begin
            d16 = 16'($random(seed));
            apb(1'b1, t ? `GIO_OFS_EDGE_HI : `GIO_OFS_IEN_HI, {16'h0, d16}, q);
            apb(1'b0, t ? `GIO_OFS_EDGE_HI : `GIO_OFS_IEN_HI, 32'h0, q);
            chk(q, {32'h0, d16}, "hi config readback");
            apb(1'b1, t ? `GIO_OFS_EDGE_HI : `GIO_OFS_IEN_HI, 32'h0, q);
        end
        $display("config test done");
        for (int t = 0; t < 4; t++) begin
            v = {16'($random(seed)), 32'($random(seed))};
            drv <= {16'($random(seed)), 32'($random(seed))};
            d = 6'($random(seed));
            apb(1'b1, `GIO_OFS_DATA_LO, v[31:0], q);
            apb(1'b1, `GIO_OFS_DATA_HI, {10'h0, d, v[47:32]}, q);
            repeat (6) @(posedge core_clk_i);
            for (int g = 0; g < 6; g++) e[g*8+:8] = d[g] ? v[g*8+:8] : drv[g*8+:8];
            apb(1'b0, `GIO_OFS_DATA_LO, 32'h0, q);
            chk(q, e[31:0], "data lo");
            apb(1'b0, `GIO_OFS_DATA_HI, 32'h0, q);
            chk(q, {10'h0, d, e[47:32]}, "data hi");
        end
        $display("port test done");
        drv <= 48'h0;
        apb(1'b1, `GIO_OFS_DATA_HI, 32'h0, q);
        repeat (6) @(posedge core_clk_i);
        apb(1'b1, `GIO_OFS_STAT_LO, 32'hFFFF_FFFF, q);
        apb(1'b1, `GIO_OFS_STAT_HI, 32'hFFFF_FFFF, q);
        apb(1'b1, `GIO_OFS_IEN_LO, 32'h1, q);
        apb(1'b1, `GIO_OFS_EDGE_LO, 32'h1, q);
        drv <= 48'h3;
        repeat (6) @(posedge core_clk_i);
        chk(irq_o, 1'b1, "irq on rise");
        drv <= 48'h7;
        repeat (2) @(posedge core_clk_i);
        drv <= 48'h3;
        repeat (6) @(posedge core_clk_i);
        apb(1'b0, `GIO_OFS_STAT_LO, 32'h0, q);
        chk(q, 48'h1, "edge match, glitch dropped");
        apb(1'b1, `GIO_OFS_IEN_LO, 32'h0, q);
        chk(irq_o, 1'b0, "masked");
        drv <= 48'h1;
        repeat (6) @(posedge core_clk_i);
        apb(1'b1, `GIO_OFS_STAT_LO, 32'h1, q);
        apb(1'b0, `GIO_OFS_STAT_LO, 32'h0, q);
        chk(q, 48'h2, "w1c and fall");
        apb(1'b1, `GIO_OFS_IEN_LO, 32'h2, q);
        chk(irq_o, 1'b1, "enable pending");
        apb(1'b1, `GIO_OFS_STAT_LO, 32'h2, q);
        chk(irq_o, 1'b0, "cleared");
        $display("irq test done");
        end_of_test();
    end
    task automatic end_of_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
